/* File: rtl/process_watchdog_map.vh */
// Timing, reset values and state codes for the process watchdog and state control block
`ifndef PROCESS_WATCHDOG_MAP_VH
`define PROCESS_WATCHDOG_MAP_VH

// Wishbone register byte offsets
`define OFS_CONTROL 4'h0
`define OFS_MULTIPLIER 4'h4
`define OFS_PROC_TIMER 4'h8
`define OFS_LOCAL_TIMER 4'hc

// Control register fields
`define CTL_PROC_EN 0
`define CTL_LOCAL_EN 1
`define CTL_MANUAL 2
`define CTL_REQ_LSB 4
`define CTL_REQ_MSB 6

// Status fields returned in the control register
`define STS_PROC_EXP 8
`define STS_LOCAL_EXP 9
`define STS_STATE_LSB 12
`define STS_STATE_MSB 14

// Reset values
`define MULT_RESET 16'h09c2
`define PROC_TIMER_RESET 16'h03e8
`define LOCAL_TIMER_RESET 16'h03e8
`define CONTROL_RESET 3'h3

// Base period of the local tick clock
`define BASE_PERIOD_NS 40
`define REF_PERIOD_NS 8
`define BASE_TICK_CYCLES (`BASE_PERIOD_NS / `REF_PERIOD_NS)
`define WATCHDOG_EXTRA_BASE 2

// Slave state machine codes
`define ST_INIT 3'h1
`define ST_PREOP 3'h2
`define ST_BOOT 3'h3
`define ST_SAFEOP 3'h4
`define ST_RUN 3'h0

`endif

/* File: rtl/process_watchdog_state_control.v */
// Dual communication watchdog and slave state machine with output safety gating
// Operation
// - Restart process watchdog only on good exchange
// - Process watchdog expiry forces outputs false
// - Expiry leaves slave state untouched
// - Local interface watchdog fires on idle
// - Both watchdogs default to 100 ms
// - Shared multiplier tick, separate timer values
// - Tick equals multiplier plus two base periods
// - Multiplier resets to 2498
// - Process timer resets to 1000 ticks
// - Timer 0..65535, multiplier 1..65535
// - Timer zero disables process watchdog entirely
// - Settings loaded only at start-up, manual mode
// - Power-up enters initial state, no traffic
// - Check mailbox setup before configured state
// - Configured state: mailbox only, no process data
// - Check channels, copy inputs before inputs-only
// - Inputs-only: traffic allowed, outputs safe
// - Master normally brings slave to running
// - Running copies outputs, all traffic allowed
// - Update state only from initial, file mailbox
`timescale 1ns/10ps
`default_nettype none
`include "process_watchdog_map.vh"

module process_watchdog_state_control (
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Wishbone classic slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Bus-side traffic events
   input wire procExchangeOk,
   input wire [15:0] procOutData,
   input wire mailboxSetupOk,
   input wire procChannelsOk,
   // Local processor interface
   input wire localAccess,
   input wire [15:0] localInputs,
   // Physical outputs and status
   output reg [15:0] physOutputs,
   output reg [15:0] inputSnapshot,
   output reg mailboxAllowed,
   output reg fileMailboxOnly,
   output reg procDataAllowed,
   output reg procWdExpired,
   output reg localWdExpired,
   output reg [2:0] slaveState,
   output reg stateAck
);

   reg [2:0] control;
   reg [2:0] stateReq;
   reg [15:0] multiplier;
   reg [15:0] procTimer;
   reg [15:0] localTimer;
   reg startupDone;
   reg [2:0] baseCnt;
   reg [16:0] tickCnt;
   reg tick;
   reg [16:0] procCount;
   reg [16:0] localCount;
   reg [2:0] next_slaveState;
   reg [31:0] next_rdata;
   reg next_mailboxAllowed;
   reg next_fileMailboxOnly;
   reg next_procDataAllowed;
   reg next_snapshotLoad;
   reg localSync1;
   reg localSync2;
   reg localSync3;
   reg localAccessClean;

   wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wbWrite = wbReq & wb_we_i;
   wire baseTick = (baseCnt == `BASE_TICK_CYCLES - 1);
   wire [16:0] tickLen = {1'b0, multiplier} + 17'd`WATCHDOG_EXTRA_BASE;

   // Lane-merged 16-bit write
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] sel;
      begin
         merge16 = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   // Process data may flow in inputs-only and running
   function isDataState;
      input [2:0] st;
      begin
         isDataState = (st == `ST_SAFEOP) || (st == `ST_RUN);
      end
   endfunction

   // Mailbox traffic is closed only in the initial state
   function isMailboxState;
      input [2:0] st;
      begin
         isMailboxState = (st != `ST_INIT);
      end
   endfunction

   // Expiry test shared by both watchdogs
   function overLimit;
      input [16:0] cnt;
      input [15:0] limit;
      begin
         overLimit = (cnt > {1'b0, limit});
      end
   endfunction

   // Candidate register values after byte-lane merge
   wire [15:0] multMerged = merge16(multiplier, wb_dat_i, wb_sel_i);
   wire [15:0] procTimerMerged = merge16(procTimer, wb_dat_i, wb_sel_i);
   wire [15:0] localTimerMerged = merge16(localTimer, wb_dat_i, wb_sel_i);
   // Settings load only in manual mode before start-up ends
   wire settingsOpen = control[`CTL_MANUAL] & ~startupDone;
   // A zero timer switches its watchdog off
   wire procWdOn = control[`CTL_PROC_EN] & (procTimer != 16'h0000);
   wire localWdOn = control[`CTL_LOCAL_EN] & (localTimer != 16'h0000);
   wire procRestart = procExchangeOk & procDataAllowed;
   wire [16:0] procNext = procCount + 17'h00001;
   wire [16:0] localNext = localCount + 17'h00001;

   // Register file; timers only take writes before start-up ends, in manual mode
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         control <= `CONTROL_RESET;
         stateReq <= `ST_INIT;
         multiplier <= `MULT_RESET;
         procTimer <= `PROC_TIMER_RESET;
         localTimer <= `LOCAL_TIMER_RESET;
         startupDone <= 1'b0;
      end else begin
         if (slaveState != `ST_INIT) begin
            startupDone <= 1'b1;
         end
         if (wbWrite) begin
            // Control write also carries the requested state
            case (wb_adr_i)
               `OFS_CONTROL: begin
                  if (wb_sel_i[0]) begin
                     control <= wb_dat_i[2:0];
                     stateReq <= wb_dat_i[`CTL_REQ_MSB:`CTL_REQ_LSB];
                  end
               end
               `OFS_MULTIPLIER: begin
                  if (settingsOpen && multMerged != 16'h0000) begin
                     multiplier <= multMerged;
                  end
               end
               `OFS_PROC_TIMER: begin
                  if (settingsOpen) begin
                     procTimer <= procTimerMerged;
                  end
               end
               `OFS_LOCAL_TIMER: begin
                  if (settingsOpen) begin
                     localTimer <= localTimerMerged;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always @* begin
      next_rdata = 32'h00000000;
      case (wb_adr_i)
         `OFS_CONTROL: begin
            next_rdata[2:0] = control;
            next_rdata[`CTL_REQ_MSB:`CTL_REQ_LSB] = stateReq;
            next_rdata[`STS_PROC_EXP] = procWdExpired;
            next_rdata[`STS_LOCAL_EXP] = localWdExpired;
            next_rdata[`STS_STATE_MSB:`STS_STATE_LSB] = slaveState;
         end
         `OFS_MULTIPLIER: next_rdata[15:0] = multiplier;
         `OFS_PROC_TIMER: next_rdata[15:0] = procTimer;
         `OFS_LOCAL_TIMER: next_rdata[15:0] = localTimer;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Single-cycle ack, dropped the cycle after
   // Back-to-back requests see ack every other cycle
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wbReq;
         if (wbReq) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   // 40 ns base enable, then watchdog tick every multiplier+2 bases
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         baseCnt <= 3'h0;
         tickCnt <= 17'h00000;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (baseTick) begin
            baseCnt <= 3'h0;
            if (tickCnt >= tickLen - 17'h00001) begin
               tickCnt <= 17'h00000;
               tick <= 1'b1;
            end else begin
               tickCnt <= tickCnt + 17'h00001;
            end
         end else begin
            baseCnt <= baseCnt + 3'h1;
         end
      end
   end

   // Process channel watchdog
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         procCount <= 17'h00000;
         procWdExpired <= 1'b0;
      end else if (!procWdOn) begin
         procCount <= 17'h00000;
         procWdExpired <= 1'b0;
      end else if (procRestart) begin
         procCount <= 17'h00000;
         procWdExpired <= 1'b0;
      end else if (tick && !procWdExpired) begin
         procCount <= procNext;
         if (overLimit(procNext, procTimer)) begin
            procWdExpired <= 1'b1;
         end
      end
   end

   // Three-stage synchroniser; a change counts once stages two and three agree
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         localSync1 <= 1'b0;
         localSync2 <= 1'b0;
         localSync3 <= 1'b0;
         localAccessClean <= 1'b0;
      end else begin
         localSync1 <= localAccess;
         localSync2 <= localSync1;
         localSync3 <= localSync2;
         if (localSync2 == localSync3) begin
            localAccessClean <= localSync3;
         end
      end
   end

   // Local interface watchdog
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         localCount <= 17'h00000;
         localWdExpired <= 1'b0;
      end else if (!localWdOn) begin
         localCount <= 17'h00000;
         localWdExpired <= 1'b0;
      end else if (localAccessClean) begin
         localCount <= 17'h00000;
         localWdExpired <= 1'b0;
      end else if (tick && !localWdExpired) begin
         localCount <= localNext;
         if (overLimit(localNext, localTimer)) begin
            localWdExpired <= 1'b1;
         end
      end
   end

   // Slave state transitions; watchdogs do not feed in here
   always @* begin
      next_slaveState = slaveState;
      case (slaveState)
         `ST_INIT: begin
            if (stateReq == `ST_PREOP && mailboxSetupOk) begin
               next_slaveState = `ST_PREOP;
            end else if (stateReq == `ST_BOOT) begin
               next_slaveState = `ST_BOOT;
            end
         end
         `ST_PREOP: begin
            if (stateReq == `ST_INIT) begin
               next_slaveState = `ST_INIT;
            end else if (stateReq == `ST_SAFEOP && procChannelsOk) begin
               next_slaveState = `ST_SAFEOP;
            end
         end
         `ST_SAFEOP: begin
            if (stateReq == `ST_INIT || stateReq == `ST_PREOP) begin
               next_slaveState = stateReq;
            end else if (stateReq == `ST_RUN) begin
               next_slaveState = `ST_RUN;
            end
         end
         `ST_RUN: begin
            if (stateReq != `ST_RUN && stateReq != `ST_BOOT) begin
               next_slaveState = stateReq;
            end
         end
         `ST_BOOT: begin
            if (stateReq == `ST_INIT) begin
               next_slaveState = `ST_INIT;
            end
         end
         default: next_slaveState = `ST_INIT;
      endcase
   end

   // Permissions follow the state being entered
   always @* begin
      next_mailboxAllowed = isMailboxState(next_slaveState);
      next_fileMailboxOnly = (next_slaveState == `ST_BOOT);
      next_procDataAllowed = isDataState(next_slaveState);
      next_snapshotLoad = isDataState(next_slaveState);
   end

   // State register and per-state permissions
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slaveState <= `ST_INIT;
         stateAck <= 1'b0;
         mailboxAllowed <= 1'b0;
         fileMailboxOnly <= 1'b0;
         procDataAllowed <= 1'b0;
         inputSnapshot <= 16'h0000;
      end else begin
         slaveState <= next_slaveState;
         stateAck <= (next_slaveState != slaveState);
         // Snapshot lands with the state change, so inputs are in place at the ack
         if (next_snapshotLoad) begin
            inputSnapshot <= localInputs;
         end
         mailboxAllowed <= next_mailboxAllowed;
         fileMailboxOnly <= next_fileMailboxOnly;
         procDataAllowed <= next_procDataAllowed;
      end
   end

   // Output gating: only running and watchdog quiet drives data
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         physOutputs <= 16'h0000;
      end else if (slaveState != `ST_RUN) begin
         physOutputs <= 16'h0000;
      end else if (procExchangeOk) begin
         // A fresh exchange restarts the watchdog, so it beats a stale expiry
         physOutputs <= procOutData;
      end else if (procWdExpired) begin
         physOutputs <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

/* File: tb/fieldbus_master_model.sv */
// Behavioural fieldbus master issuing process data exchanges
`timescale 1ns/10ps
`default_nettype none
module fieldbus_master_model (
   // Clock
   input wire logic ref_clk,
   // Frame request from the bench
   input wire logic sendReq,
   input wire logic [15:0] sendData,
   // Toward the block
   output var logic procExchangeOk = 1'h0,
   output var logic [15:0] procOutData = 16'h0
);
   // One pulse per frame, data scrambled outside frames
   always @(posedge ref_clk) begin
      procExchangeOk <= sendReq;
      procOutData <= sendReq ? sendData : ~procOutData;
   end
endmodule
`default_nettype wire

/* File: tb/process_watchdog_checker_sva.sv */
// Assertions on the watchdog and state control ports
`timescale 1ns/10ps
`default_nettype none
`include "process_watchdog_map.vh"
module process_watchdog_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Bus handshake
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Traffic and outputs
   input wire logic procExchangeOk,
   input wire logic [15:0] procOutData,
   input wire logic [15:0] physOutputs,
   input wire logic mailboxAllowed,
   input wire logic fileMailboxOnly,
   input wire logic procDataAllowed,
   input wire logic procWdExpired,
   input wire logic localWdExpired,
   input wire logic [2:0] slaveState,
   input wire logic stateAck
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   property p_restart;
      procExchangeOk && procDataAllowed |=> !procWdExpired;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");
   property p_expire;
      procWdExpired [*2] |-> physOutputs == 16'h0;
   endproperty
   a_expire: assert property (p_expire) else $error("outputs live");
   property p_init;
      slaveState == `ST_INIT |-> !mailboxAllowed && !procDataAllowed;
   endproperty
   a_init: assert property (p_init) else $error("init traffic");
   property p_preop;
      slaveState == `ST_PREOP |-> mailboxAllowed && !procDataAllowed;
   endproperty
   a_preop: assert property (p_preop) else $error("config traffic");
   property p_copy;
      procExchangeOk && slaveState == `ST_RUN |=> physOutputs == $past(procOutData);
   endproperty
   a_copy: assert property (p_copy) else $error("no copy");
   property p_boot;
      slaveState == `ST_BOOT |-> fileMailboxOnly && !procDataAllowed;
   endproperty
   a_boot: assert property (p_boot) else $error("update traffic");
   property p_state_ack;
      $changed(slaveState) |-> stateAck;
   endproperty
   a_state_ack: assert property (p_state_ack) else $error("no state ack");
   c_run: cover property (slaveState == `ST_RUN && procExchangeOk);
   c_exp: cover property ($rose(procWdExpired));
   c_local: cover property ($rose(localWdExpired));
endmodule
bind process_watchdog_state_control process_watchdog_checker u_process_watchdog_checker (.ref_clk, .rst_n,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .procExchangeOk, .procOutData, .physOutputs, .mailboxAllowed,
   .fileMailboxOnly, .procDataAllowed, .procWdExpired, .localWdExpired, .slaveState, .stateAck);
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the watchdog and state control block
`timescale 1ns/10ps
`default_nettype none
`include "process_watchdog_map.vh"
module testbench;
   logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, procExchangeOk, mailboxSetupOk;
   logic procChannelsOk, localAccess, sendReq, mailboxAllowed, fileMailboxOnly, procDataAllowed;
   logic procWdExpired, localWdExpired, stateAck;
   logic [3:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] procOutData, localInputs, sendData, physOutputs, inputSnapshot;
   logic [2:0] slaveState;
   int failures, checks_done, n;
   process_watchdog_state_control u_process_watchdog_state_control (.ref_clk, .rst_n, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h3), .wb_dat_i, .wb_dat_o, .wb_ack_o, .procExchangeOk,
      .procOutData, .mailboxSetupOk, .procChannelsOk, .localAccess, .localInputs, .physOutputs,
      .inputSnapshot, .mailboxAllowed, .fileMailboxOnly, .procDataAllowed, .procWdExpired,
      .localWdExpired, .slaveState, .stateAck);
   fieldbus_master_model u_fieldbus_master_model (.ref_clk, .sendReq, .sendData, .procExchangeOk,
      .procOutData);
   task automatic final_report;
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      int k;
      k = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge ref_clk);
         k++;
      end while (wb_ack_o !== 1'h1 && k < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      chk(wb_ack_o, 1'h1);
      if (wb_ack_o !== 1'h1) final_report();
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'h1, adr, wd, rd);
   endtask
   task automatic rdc(input logic [3:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'h0, adr, 32'h0, rd);
      chk(rd, exp);
   endtask
   task automatic step(input logic [31:0] ctl);
      wr(`OFS_CONTROL, ctl);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic frame(input logic [15:0] d);
      sendReq <= 1'h1;
      sendData <= d;
      @(posedge ref_clk);
      sendReq <= 1'h0;
      repeat (3) @(posedge ref_clk);
   endtask
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, sendReq, mailboxSetupOk, procChannelsOk} = 7'h0;
      {wb_adr_i, wb_dat_i, sendData} = 52'h0;
      localAccess = 1'h1;
      localInputs = 16'h5a3c;
      failures = 0;
      checks_done = 0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      rdc(`OFS_CONTROL, 32'h1013);
      rdc(`OFS_MULTIPLIER, 32'h9c2);
      rdc(`OFS_PROC_TIMER, 32'h3e8);
      rdc(`OFS_LOCAL_TIMER, 32'h3e8);
      rdc(4'h2, 32'h0);
      $display("test reset_values done");
      wr(`OFS_CONTROL, 32'h17);
      wr(`OFS_MULTIPLIER, 32'h0);
      rdc(`OFS_MULTIPLIER, 32'h9c2);
      wr(`OFS_MULTIPLIER, 32'h1);
      wr(`OFS_PROC_TIMER, 32'h2);
      wr(`OFS_LOCAL_TIMER, 32'h3);
      rdc(`OFS_PROC_TIMER, 32'h2);
      step(32'h27);
      chk(slaveState, `ST_INIT);
      mailboxSetupOk <= 1'h1;
      step(32'h27);
      chk({mailboxAllowed, procDataAllowed, slaveState}, {2'h2, `ST_PREOP});
      wr(`OFS_MULTIPLIER, 32'h5);
      rdc(`OFS_MULTIPLIER, 32'h1);
      $display("test start_up done");
      procChannelsOk <= 1'h1;
      step(32'h47);
      chk({procDataAllowed, slaveState, inputSnapshot}, {1'h1, `ST_SAFEOP, 16'h5a3c});
      frame(16'h1111);
      chk(physOutputs, 16'h0);
      step(32'h07);
      frame(16'ha5c3);
      chk({procWdExpired, physOutputs}, {1'h0, 16'ha5c3});
      for (n = 0; procWdExpired !== 1'h1 && n < 200; n++) @(posedge ref_clk);
      chk(n >= 25 && n <= 50, 1'h1);
      if (n >= 200) final_report();
      @(posedge ref_clk);
      chk({slaveState, physOutputs}, {`ST_RUN, 16'h0});
      frame(16'h1234);
      chk({procWdExpired, physOutputs}, {1'h0, 16'h1234});
      $display("test process_watchdog done");
      localAccess <= 1'h0;
      for (n = 0; localWdExpired !== 1'h1 && n < 200; n++) @(posedge ref_clk);
      chk(n >= 40 && n <= 70, 1'h1);
      if (n >= 200) final_report();
      $display("test local_watchdog done");
      rst_n <= 1'h0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      rdc(`OFS_MULTIPLIER, 32'h9c2);
      wr(`OFS_CONTROL, 32'h17);
      wr(`OFS_MULTIPLIER, 32'h1);
      wr(`OFS_PROC_TIMER, 32'h0);
      repeat (100) @(posedge ref_clk);
      chk(procWdExpired, 1'h0);
      step(32'h33);
      chk({fileMailboxOnly, procDataAllowed, slaveState}, {2'h2, `ST_BOOT});
      $display("test boot done");
      final_report();
   end
endmodule
`default_nettype wire
